/* File: core/rdsp_pkg.sv */
// Constants shared by both ends of the two-wire data port.
// Assumes a 50 MHz core clock on both ends and a bus clock far slower.
// Function
// - Master opens with START, address, direction
// - Device answers upper address bits 001000
// - Address low bit from select pin
// - Bytes shifted most significant bit first
// - Receiver acknowledges every byte low but the last read byte
// - Master ends every transfer with STOP
// - STOP at byte boundary ends cleanly
// - Write error: no acknowledge, master stops
// - Write sends up to three bytes
// - Read returns up to seven bytes
// - Master acks six, nacks seventh, stops
// - New set each 21.9 ms, flag 2 us later
// - Flag low 10.1 ms unless read earlier
// - Quality measurement done within 850 us
package rdsp_pkg;
	// ---------------------------------------------------------------
	// Bus framing
	// ---------------------------------------------------------------
	localparam logic [5:0] ADDR_UPPER  = 6'h08;   // 001000
	localparam int         WR_BYTES    = 3;
	localparam int         RD_BYTES    = 7;
	localparam int         BITS        = 8;
	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_MHZ              = 50;
	localparam int PERIOD_US            = 21900;  // 21.9 ms set period
	localparam int VALID_TO_FLAG_NS     = 2000;   // 2.0 us
	localparam int FLAG_LOW_US          = 10100;  // 10.1 ms
	localparam int QUALITY_MEASURE_US   = 850;
	localparam int PERIOD_CYC   = PERIOD_US * CLK_MHZ;
	localparam int VALID_TO_FLAG_CYC = VALID_TO_FLAG_NS * CLK_MHZ / 1000;
	localparam int FLAG_LOW_CYC = FLAG_LOW_US * CLK_MHZ;
	localparam int QUALITY_MEASURE_CYC = QUALITY_MEASURE_US * CLK_MHZ;
	localparam int HALF_BIT_DIV = 200;            // Master bus clock quarter period (one sequencer phase)
endpackage

/* File: core/rdsp_link_if.sv */
// Open-drain bus wires between the two ends, with one modport each.
// Assumes both sides drive enables active low as in the design ends.
`timescale 1ns/1ns
interface rdsp_link_if;
	logic scl_out_en_n;
	logic sda_m_out_en_n;
	logic sda_s_out_en_n;
	logic scl;
	logic sda;
	// Wired-and: any enabled driver pulls low
	assign scl = scl_out_en_n;
	assign sda = sda_m_out_en_n & sda_s_out_en_n;
	modport device (input scl, input sda, output sda_s_out_en_n);
	modport master (input scl, input sda, output scl_out_en_n, output sda_m_out_en_n);
endinterface

/* File: core/rdsp_device.sv */
// Device end: two-wire slave holding write bytes and serving read snapshots.
// Assumes sda and scl are asynchronous to clk_i; new data sets arrive on data_set_i.
`timescale 1ns/1ns
module rdsp_device #(
	parameter int PERIOD_CYC  = rdsp_pkg::PERIOD_CYC,
	parameter int FLAG_CYC    = rdsp_pkg::FLAG_LOW_CYC,
	parameter int QUALITY_CYC = rdsp_pkg::QUALITY_MEASURE_CYC
) (
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	rdsp_link_if.device      link,
	input  wire logic        address_select_pin_i,
	input  wire logic [55:0] data_set_i,
	output logic      [23:0] write_bytes_o,
	output logic             data_available_n_o,
	output logic             quality_done_o,
	output logic             data_set_req_o
);
	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_TXACK, ST_SKIP
	} rdsp_dev_st_t;
	typedef struct packed {
		logic [1:0]  scl_s, sda_s;
		logic [1:0]  sel_s;
		logic        scl_d, sda_d;
		rdsp_dev_st_t st;
		logic [3:0]  bit_cnt;
		logic [7:0]  shift;
		logic        rd;
		logic [2:0]  byte_idx;
		logic        ack_low;
		logic [55:0] snap;
		logic [23:0] wbytes;
		logic [31:0] per_cnt;
		logic [31:0] dly_cnt;
		logic [31:0] flag_cnt;
		logic        flag_n;
		logic [31:0] q_cnt;
		logic        q_done;
		logic        set_req;
	} rdsp_dev_t;
	rdsp_dev_t s_reg, s_next;

	logic scl_rise, scl_fall, start_c, stop_c;
	always_comb begin
		scl_rise = s_reg.scl_s[1] & ~s_reg.scl_d;
		scl_fall = ~s_reg.scl_s[1] & s_reg.scl_d;
		start_c  = s_reg.scl_s[1] & s_reg.sda_d & ~s_reg.sda_s[1];
		stop_c   = s_reg.scl_s[1] & ~s_reg.sda_d & s_reg.sda_s[1];
	end

	// ---------------------------------------------------------------
	// Protocol engine and data-set timers
	// ---------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.scl_s = {s_reg.scl_s[0], link.scl};
		s_next.sda_s = {s_reg.sda_s[0], link.sda};
		// Select pin is a board level, so it passes two flops like the bus wires
		s_next.sel_s = {s_reg.sel_s[0], address_select_pin_i};
		s_next.scl_d = s_reg.scl_s[1];
		s_next.sda_d = s_reg.sda_s[1];
		s_next.set_req = 1'b0;
		// Set period and flag delay
		if (s_reg.per_cnt >= 32'(PERIOD_CYC - 1)) begin
			s_next.per_cnt = '0;
			s_next.set_req = 1'b1;
			s_next.dly_cnt = 32'(rdsp_pkg::VALID_TO_FLAG_CYC);
		end else begin
			s_next.per_cnt = s_reg.per_cnt + 32'h1;
		end
		// Flag released after its low time unless a read took it
		if (s_reg.flag_cnt != '0) begin
			s_next.flag_cnt = s_reg.flag_cnt - 32'h1;
			if (s_reg.flag_cnt == 32'h1)
				s_next.flag_n = 1'b1;
		end
		// Placed after the release so a new set wins a same-cycle release
		if (s_reg.dly_cnt != '0) begin
			s_next.dly_cnt = s_reg.dly_cnt - 32'h1;
			if (s_reg.dly_cnt == 32'h1) begin
				s_next.flag_n   = 1'b0;
				s_next.flag_cnt = 32'(FLAG_CYC);
			end
		end
		// Quality measurement window
		if (s_reg.q_cnt != '0) begin
			s_next.q_cnt = s_reg.q_cnt - 32'h1;
			if (s_reg.q_cnt == 32'h1)
				s_next.q_done = 1'b1;
		end
		// Bus state machine
		if (stop_c) begin
			s_next.st = ST_IDLE;
			s_next.ack_low = 1'b0;
		end else if (start_c) begin
			s_next.st = ST_ADDR;
			s_next.bit_cnt = '0;
			s_next.byte_idx = '0;
			s_next.ack_low = 1'b0;
		end else begin
			case (s_reg.st)
			ST_IDLE, ST_SKIP: ;
			ST_ADDR, ST_RX: begin
				if (scl_rise) begin
					s_next.shift = {s_reg.shift[6:0], s_reg.sda_s[1]};
					s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
				end
				if (scl_fall && s_reg.bit_cnt == 4'(rdsp_pkg::BITS)) begin
					s_next.bit_cnt = '0;
					if (s_reg.st == ST_ADDR) begin
						if (s_reg.shift[7:2] == rdsp_pkg::ADDR_UPPER &&
							s_reg.shift[1] == s_reg.sel_s[1]) begin
							s_next.ack_low = 1'b1;
							s_next.rd = s_reg.shift[0];
							s_next.st = ST_ACK;
							s_next.q_cnt = 32'(QUALITY_CYC);
							s_next.q_done = 1'b0;
							if (s_reg.shift[0]) begin
								s_next.snap = data_set_i;
								// A flag being set this very cycle wins
								if (s_reg.dly_cnt != 32'h1) begin
									s_next.flag_n = 1'b1;
									s_next.flag_cnt = '0;
								end
							end
						end else begin
							s_next.st = ST_SKIP;
						end
					end else if (s_reg.byte_idx < 3'(rdsp_pkg::WR_BYTES)) begin
						// Store byte at once so an early stop keeps it
						s_next.wbytes[23 - 8*s_reg.byte_idx -: 8] = s_reg.shift;
						s_next.byte_idx = s_reg.byte_idx + 3'h1;
						s_next.ack_low = 1'b1;
						s_next.st = ST_ACK;
					end else begin
						s_next.st = ST_SKIP;
					end
				end
			end
			ST_ACK: begin
				if (scl_fall) begin
					s_next.ack_low = 1'b0;
					if (s_reg.rd) begin
						s_next.st = ST_TX;
						s_next.shift = s_reg.snap[55 - 8*s_reg.byte_idx -: 8];
						s_next.ack_low = ~s_reg.snap[55 - 8*s_reg.byte_idx];
						s_next.bit_cnt = 4'h1;
					end else begin
						s_next.st = ST_RX;
					end
				end
			end
			ST_TX: begin
				if (scl_fall) begin
					if (s_reg.bit_cnt == 4'(rdsp_pkg::BITS)) begin
						s_next.ack_low = 1'b0;
						s_next.st = ST_TXACK;
					end else begin
						s_next.shift = {s_reg.shift[6:0], 1'b0};
						s_next.ack_low = ~s_reg.shift[6];
						s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
					end
				end
			end
			ST_TXACK: begin
				if (scl_rise) begin
					// Master nack or last byte ends our driving
					if (s_reg.sda_s[1] || s_reg.byte_idx == 3'(rdsp_pkg::RD_BYTES - 1)) begin
						s_next.st = ST_SKIP;
					end else begin
						s_next.byte_idx = s_reg.byte_idx + 3'h1;
						s_next.st = ST_ACK;
					end
				end
			end
			default: s_next.st = ST_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			s_reg <= '0;
			s_reg.scl_s <= 2'h3;
			s_reg.sda_s <= 2'h3;
			s_reg.scl_d <= 1'b1;
			s_reg.sda_d <= 1'b1;
			s_reg.st <= ST_IDLE;
			s_reg.flag_n <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	// In ACK state of a read, ack_low drives only the address ack (bit_cnt zero); TX drives data bits
	assign link.sda_s_out_en_n = ~(s_reg.ack_low && (s_reg.st != ST_ACK || !s_reg.rd ||
		s_reg.bit_cnt == '0));
	assign write_bytes_o      = s_reg.wbytes;
	assign data_available_n_o = s_reg.flag_n;
	assign quality_done_o     = s_reg.q_done;
	assign data_set_req_o     = s_reg.set_req;
endmodule

/* File: core/rdsp_master.sv */
// Master end: generates bus clock by divider, runs one write or read per request.
// Assumes the user holds req_i until busy_o rises.
`timescale 1ns/1ns
module rdsp_master #(
	parameter int DIV = rdsp_pkg::HALF_BIT_DIV
) (
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	rdsp_link_if.master      link,
	input  wire logic        req_i,
	input  wire logic        read_i,
	input  wire logic [6:0]  addr_i,
	input  wire logic [2:0]  count_i,
	input  wire logic [23:0] wdata_i,
	output logic [55:0]      rdata_o,
	output logic             nack_o,
	output logic             busy_o,
	output logic             done_o
);
	typedef enum logic [2:0] {M_IDLE, M_START, M_BIT, M_STOP, M_DONE} rdsp_mst_st_t;
	typedef struct packed {
		logic [1:0]  sda_s;
		rdsp_mst_st_t st;
		logic [15:0] div;
		logic [1:0]  ph;
		logic [3:0]  bit_cnt;
		logic [2:0]  byte_idx;
		logic [8:0]  shift;
		logic [55:0] rbuf;
		logic        rd;
		logic [2:0]  cnt;
		logic [23:0] wd;
		logic        scl_lo, sda_lo;
		logic        nack;
		logic        done;
	} rdsp_mst_t;
	rdsp_mst_t m_reg, m_next;
	logic tick;
	assign tick = (m_reg.div == 16'(DIV - 1));

	// ---------------------------------------------------------------
	// Transfer sequencer: each bit has four quarter phases
	// ---------------------------------------------------------------
	always_comb begin
		m_next = m_reg;
		m_next.sda_s = {m_reg.sda_s[0], link.sda};
		m_next.done = 1'b0;
		m_next.div = tick ? '0 : m_reg.div + 16'h1;
		case (m_reg.st)
		M_IDLE: begin
			m_next.scl_lo = 1'b0;
			m_next.sda_lo = 1'b0;
			if (req_i) begin
				m_next.st = M_START;
				m_next.rd = read_i;
				m_next.cnt = count_i;
				m_next.wd = wdata_i;
				m_next.shift = {addr_i, read_i, 1'b1};
				m_next.bit_cnt = '0;
				m_next.byte_idx = '0;
				m_next.nack = 1'b0;
				m_next.ph = '0;
				m_next.div = '0;
			end
		end
		M_START: if (tick) begin
			m_next.sda_lo = 1'b1;
			m_next.st = M_BIT;
		end
		M_BIT: if (tick) begin
			m_next.ph = m_reg.ph + 2'h1;
			case (m_reg.ph)
			2'h0: begin
				m_next.scl_lo = 1'b1;
			end
			2'h1: m_next.sda_lo = ~m_reg.shift[8];
			2'h2: m_next.scl_lo = 1'b0;
			default: begin
				m_next.shift = {m_reg.shift[7:0], m_reg.sda_s[1]};
				m_next.bit_cnt = m_reg.bit_cnt + 4'h1;
				if (m_reg.bit_cnt == 4'(rdsp_pkg::BITS)) begin
					m_next.bit_cnt = '0;
					if (m_reg.rd && m_reg.byte_idx != '0)
						m_next.rbuf[63 - 8*m_reg.byte_idx -: 8] = m_reg.shift[7:0];
					if (m_reg.sda_s[1] && !(m_reg.rd && m_reg.byte_idx != '0)) begin
						m_next.nack = 1'b1;
						m_next.st = M_STOP;
					// Write: index 0 is the address, so stop after byte cnt[1:0]+1, never past three
					end else if (!m_reg.rd && (m_reg.byte_idx == {1'b0, m_reg.cnt[1:0]} + 3'h1 ||
						m_reg.byte_idx == 3'(rdsp_pkg::WR_BYTES)) ||
						m_reg.rd && m_reg.byte_idx == m_reg.cnt) begin
						m_next.st = M_STOP;
					end else begin
						m_next.byte_idx = m_reg.byte_idx + 3'h1;
						// Read: release data, ack unless last requested byte
						m_next.shift = m_reg.rd ?
							{8'hFF, (m_reg.byte_idx + 3'h1 == m_reg.cnt)} :
							{m_reg.wd[23 - 8*m_reg.byte_idx -: 8], 1'b1};
					end
				end
			end
			endcase
		end
		M_STOP: if (tick) begin
			m_next.scl_lo = 1'b1;
			m_next.ph = m_reg.ph + 2'h1;
			if (m_reg.ph == 2'h0) m_next.sda_lo = 1'b1;
			if (m_reg.ph == 2'h1) m_next.scl_lo = 1'b0;
			if (m_reg.ph == 2'h2) begin
				m_next.scl_lo = 1'b0;
				m_next.sda_lo = 1'b0;
				m_next.st = M_DONE;
			end
			if (m_reg.ph >= 2'h2) m_next.scl_lo = 1'b0;
		end
		M_DONE: begin
			m_next.done = 1'b1;
			m_next.st = M_IDLE;
		end
		default: m_next.st = M_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			m_reg <= '0;
			m_reg.sda_s <= 2'h3;
			m_reg.st <= M_IDLE;
		end else begin
			m_reg <= m_next;
		end
	end

	assign link.scl_out_en_n  = ~m_reg.scl_lo;
	assign link.sda_m_out_en_n = ~m_reg.sda_lo;
	assign rdata_o = m_reg.rbuf;
	assign nack_o  = m_reg.nack;
	assign busy_o  = (m_reg.st != M_IDLE);
	assign done_o  = m_reg.done;
endmodule

/* File: tb/rdsp_link_checker.sv */
// Bus checker for the open-drain link between master end and device end.
// Assumes it is instantiated beside the link interface; inputs are its wires.
`timescale 1ns/1ns
module rdsp_link_checker (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic scl,
	input wire logic sda,
	input wire logic scl_out_en_n,
	input wire logic sda_m_out_en_n,
	input wire logic sda_s_out_en_n
);
	// ----------------------------------------
	// Wire properties
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	// Device may only move its line while the clock is low
	chk_dev_sda_stable: assert property (scl && $past(scl) |-> $stable(sda_s_out_en_n))
		else $error("device data moved while clock high");
	// Both ends never pull together while the clock is high
	chk_no_contention: assert property (scl |-> sda_m_out_en_n || sda_s_out_en_n)
		else $error("both ends pull data while clock high");
	// Only the master makes a start
	chk_start_master: assert property (scl && $fell(sda) |-> sda_s_out_en_n)
		else $error("device pulled data at start");
	// Device stays off the line after a stop
	chk_stop_release: assert property (scl && $rose(sda) |-> sda_s_out_en_n [*8])
		else $error("device drives after stop");
	// Bus rests idle after a stop
	chk_stop_idle: assert property (scl && $rose(sda) |=> scl [*4])
		else $error("clock moved right after stop");
	// Clock high phase lasts at least eight cycles
	chk_scl_high_width: assert property ($rose(scl) |-> scl [*8])
		else $error("clock high phase too short");
	// Clock never parks low inside a frame
	chk_scl_low_bound: assert property ($fell(scl) |-> ##[1:40] scl)
		else $error("clock held low too long");
	// Bus released when reset ends
	chk_reset_idle: assert property ($fell(reset_i) |-> scl && sda && scl_out_en_n)
		else $error("bus not idle after reset");
endmodule

/* File: tb/rds_data_i2c_slave_port_tb_top.sv */
// Bench joining master end and device end through the link interface.
// Assumes rdsp_pkg, the link interface and both ends are compiled first.
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
	$display("[ERR] %0t %h %h", $time, (a), (b)); end end
`define WAITF(c, n) begin int w; for (w = 0; w < (n) && !(c); w++) begin \
	@(posedge clk_i); #1; end if (!(c)) begin n_errors++; conclude(); end end
module rds_data_i2c_slave_port_tb_top;
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	localparam logic [6:0]  A0 = {rdsp_pkg::ADDR_UPPER, 1'b0};
	localparam logic [55:0] D1 = 56'hC35A817E00FF24;
	logic        clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        sel = 1'b0;
	logic        req = 1'b0;
	logic        rd = 1'b0;
	logic [6:0]  addr = 7'h00;
	logic [2:0]  cnt = 3'h0;
	logic [23:0] wd = 24'h000000;
	logic [55:0] dset = D1;
	logic [55:0] rdata;
	logic [23:0] wbytes;
	logic        nack, busy, done, flag, qd, dreq;
	int          n_errors = 0;
	int          total_checks = 0;
	time         t0;

	// Clock 50 MHz
	always #10 clk_i = ~clk_i;

	rdsp_link_if rdsp_link_if_inst ();
	// Shortened counts keep the run brief; expectations use the same values
	rdsp_device #(.PERIOD_CYC(2000), .FLAG_CYC(1000), .QUALITY_CYC(500)) rdsp_device_inst (
		.clk_i(clk_i), .reset_i(reset_i), .link(rdsp_link_if_inst),
		.address_select_pin_i(sel), .data_set_i(dset), .write_bytes_o(wbytes),
		.data_available_n_o(flag), .quality_done_o(qd), .data_set_req_o(dreq));
	rdsp_master #(.DIV(8)) rdsp_master_inst (
		.clk_i(clk_i), .reset_i(reset_i), .link(rdsp_link_if_inst), .req_i(req),
		.read_i(rd), .addr_i(addr), .count_i(cnt), .wdata_i(wd), .rdata_o(rdata),
		.nack_o(nack), .busy_o(busy), .done_o(done));
	rdsp_link_checker rdsp_link_checker_inst (
		.clk_i(clk_i), .reset_i(reset_i), .scl(rdsp_link_if_inst.scl),
		.sda(rdsp_link_if_inst.sda), .scl_out_en_n(rdsp_link_if_inst.scl_out_en_n),
		.sda_m_out_en_n(rdsp_link_if_inst.sda_m_out_en_n),
		.sda_s_out_en_n(rdsp_link_if_inst.sda_s_out_en_n));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic conclude;
		if (n_errors == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// One transfer; request held until the master shows busy
	task automatic xfer(input logic r, input logic [6:0] a, input logic [2:0] c,
			input logic [23:0] d);
		rd = r; addr = a; cnt = c; wd = d; req = 1'b1;
		`WAITF(busy, 50)
		req = 1'b0;
		`WAITF(done, 6000)
	endtask

	// Both select levels; own address acked, others refused and ignored
	task automatic sc_address;
		logic [23:0] v;
		for (int s = 0; s < 2; s++) begin
			sel = s[0];
			v = 24'hA53C81 ^ {24{s[0]}};
			xfer(1'b0, {rdsp_pkg::ADDR_UPPER, s[0]}, 3'h2, v);
			`CHK(nack, 1'b0)
			`CHK(wbytes, v)
			xfer(1'b0, {rdsp_pkg::ADDR_UPPER, ~s[0]}, 3'h0, 24'hFFFFFF);
			`CHK(nack, 1'b1)
			xfer(1'b0, {6'h09, s[0]}, 3'h0, 24'hFFFFFF);
			`CHK(nack, 1'b1)
			`CHK(wbytes, v)
		end
		sel = 1'b0;
	endtask

	// Write cut after one byte: later bytes keep old values
	task automatic sc_short_write;
		xfer(1'b0, A0, 3'h0, 24'h7E0000);
		`CHK(nack, 1'b0)
		`CHK(wbytes, 24'h7EC37E)
	endtask

	// Measurement finishes in time after the address is acknowledged
	task automatic sc_quality;
		int n;
		// Let the previous measurement finish so the count starts at this ack
		`WAITF(qd, 600)
		fork
			xfer(1'b0, A0, 3'h0, 24'h110000);
			begin
				`WAITF(!qd, 400)
				for (n = 0; n < 900 && !qd; n++) begin @(posedge clk_i); #1; end
				`CHK(n <= 504, 1'b1)
			end
		join
	endtask

	// Flag timing with no read: delay, low time and set period
	task automatic sc_flag;
		int n;
		`WAITF(dreq, 2100)
		t0 = $time;
		for (n = 0; n < 300 && flag; n++) begin @(posedge clk_i); #1; end
		`CHK(n >= 97 && n <= 103, 1'b1)
		for (n = 0; n < 2000 && !flag; n++) begin @(posedge clk_i); #1; end
		`CHK(n >= 996 && n <= 1004, 1'b1)
		`WAITF(!dreq, 10)
		`WAITF(dreq, 2100)
		`CHK(($time - t0) / 20, 64'd2000)
	endtask

	// Full read while the set changes mid-transfer; partial read after
	task automatic sc_read;
		`WAITF(!flag, 300)
		fork
			xfer(1'b1, A0, 3'h7, 24'h000000);
			begin
				`WAITF(busy, 50)
				// Address ack lands near cycle 275; look before the next set lowers it
				repeat (300) @(posedge clk_i);
				#1;
				`CHK(flag, 1'b1)
				repeat (100) @(posedge clk_i);
				#1 dset = ~D1;
			end
		join
		`CHK(rdata, D1)
		`CHK(nack, 1'b0)
		`WAITF(dreq, 2100)
		`WAITF(!flag, 300)
		xfer(1'b1, A0, 3'h2, 24'h000000);
		`CHK(rdata[55:40], ~D1[55:40])
		`CHK(nack, 1'b0)
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge clk_i);
		#1 reset_i = 1'b0;
		@(posedge clk_i);
		#1;
		`CHK({rdsp_link_if_inst.scl, rdsp_link_if_inst.sda}, 2'b11)
		sc_address();
		sc_short_write();
		sc_quality();
		sc_flag();
		sc_read();
		conclude();
	end
endmodule
